// ---- rtl/mpfc_byte_if.sv ----
// Byte stream with valid/ready between the port block and its serial engines.
// Assumes one clock for both ends.
interface mpfc_byte_if;
   logic [7:0] data;
   logic       valid;
   logic       ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface : mpfc_byte_if

// ---- rtl/mpfc_pkg.sv ----
// Types and small helpers shared by the modem port flow-control block.
// Assumes mpfc_regs.svh is on the include path.
package mpfc_pkg;
   typedef enum logic [1:0] {MPFC_FLOW_NONE = 2'b00, MPFC_FLOW_HW = 2'b01, MPFC_FLOW_SW = 2'b10} mpfc_flow_t;
   typedef enum logic [1:0] {MPFC_DCD_OFF = 2'b00, MPFC_DCD_RXD = 2'b01, MPFC_DCD_RADIO = 2'b10,
                             MPFC_DCD_PEND = 2'b11} mpfc_dcd_t;
   typedef enum logic [1:0] {MPFC_S_IDLE = 2'b00, MPFC_S_LEAD = 2'b01, MPFC_S_SEND = 2'b10,
                             MPFC_S_TAIL = 2'b11} mpfc_state_t;

   // Legal combination of handshaking, carrier-detect function and packet layer
   function automatic logic mpfc_cfg_legal(input logic [1:0] flow, input logic [1:0] dcd, input logic slip);
      logic ok;
      ok = (flow != 2'b11);
      if (flow == MPFC_FLOW_HW && dcd == MPFC_DCD_OFF) ok = 1'b0;
      if (flow != MPFC_FLOW_HW && dcd == MPFC_DCD_PEND) ok = 1'b0;
      if (flow == MPFC_FLOW_SW && slip) ok = 1'b0;
      return ok;
   endfunction : mpfc_cfg_legal

   // Pin filter: a change counts once the second and third stages agree
   function automatic logic mpfc_filt(input logic s1, input logic s2, input logic old);
      return (s1 == s2) ? s2 : old;
   endfunction : mpfc_filt
endpackage : mpfc_pkg

// ---- rtl/mpfc_regs.svh ----
// Offsets, field positions, reset values and timing figures of the port block.
// Assumes a 25 MHz system clock and a byte-addressed Avalon-MM register slave.
`ifndef MPFC_REGS_SVH
`define MPFC_REGS_SVH

`define MPFC_OFF_CTRL      4'h0
`define MPFC_OFF_STATUS    4'h4

`define MPFC_CTRL_FLOW_LSB 0
`define MPFC_CTRL_DCD_LSB  2
`define MPFC_CTRL_KEY_BIT  4
`define MPFC_CTRL_SLIP_BIT 5
`define MPFC_CTRL_RESET    6'h04

`define MPFC_ST_REJ_BIT    0
`define MPFC_ST_OVR_BIT    7

`define MPFC_CLK_KHZ       25000
`define MPFC_BAUD          9600
`define MPFC_DCD_LEAD_MS   500
`define MPFC_CHAR_BITS     10
`define MPFC_BYTE_LIMIT    4075
`define MPFC_FRAME_LIMIT   29
`define MPFC_XON_CODE      8'h11
`define MPFC_XOFF_CODE     8'h13

`endif

// ---- rtl/mpfc_top.sv ----
// Modem-side handshaking of one serial user port: DSR, DCD, CTS, RTS, DTR and XON/XOFF.
// Assumes radio-side logic on the same clock; host pins are asynchronous and filtered.
`include "mpfc_regs.svh"
import mpfc_pkg::*;

// Behaviour
// [R1] Default carrier-detect mode: DCD true while delivering received data to host.
// [R2] DCD rises about 500 ms before the first start bit of a stream.
// [R3] DCD holds about one character time after the last bit.
// [R4] DSR is always true.
// [R5] CTS is false while RTS is false.
// [R6] CTS rises within 1 ms of RTS when buffer space remains.
// [R7] CTS drops above 4075 buffered bytes or 29 queued frames.
// [R8] When enabled, RTS also keys the transmitter.
// [R9] Host drives DTR true when it can take data, false otherwise.
// [R10] Hardware mode: output to host only while DTR true.
// [R11] Resume code is 0x11, pause code is 0x13.
// [R12] Software mode ignores DTR entirely.
// [R13] Host keeps pause and resume bytes out of binary payload.
// [R14] Disabled carrier-detect mode never drives DCD active.
// [R15] Disabled carrier-detect is refused with hardware handshaking.
// [R16] Radio presence mode: DCD follows detected received radio signal.
// [R17] Data-pending mode: DCD true when data is about to be output.
// [R18] Data-pending mode is refused with no or software handshaking.
// [R19] Handshaking selects hardware, software codes, or none.
// [R20] Software codes are refused while the SLIP diagnostics layer is chosen.
// [R21] Software mode: pause code stops output, resume code restarts it.
// [R22] Software mode: send pause code near full, resume code once space returns.
module mpfc_top #(
   parameter int unsigned CLKS_PER_BIT = `MPFC_CLK_KHZ * 1000 / `MPFC_BAUD,
   parameter int unsigned LEAD_CYCLES  = `MPFC_DCD_LEAD_MS * `MPFC_CLK_KHZ,
   parameter int unsigned TAIL_CYCLES  = `MPFC_CHAR_BITS * CLKS_PER_BIT,
   parameter int unsigned BYTE_LIMIT   = `MPFC_BYTE_LIMIT,
   parameter int unsigned FRAME_LIMIT  = `MPFC_FRAME_LIMIT
) (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        reset_n_in,
   // Avalon-MM register slave
   input  wire logic [3:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic [31:0]      avs_readdata_out,
   output logic             avs_waitrequest_out,
   // Host pins
   input  wire logic        rts_in,
   input  wire logic        dtr_in,
   input  wire logic        txd_in,
   output logic             rxd_out,
   output logic             cts_out,
   output logic             dcd_out,
   output logic             dsr_out,
   // Radio side: received bytes for the host
   input  wire logic [7:0]  rx_byte_in,
   input  wire logic        rx_valid_in,
   output logic             rx_ready_out,
   input  wire logic        radio_presence_in,
   // Radio side: bytes from the host
   output logic [7:0]       tx_byte_out,
   output logic             tx_valid_out,
   input  wire logic        tx_ready_in,
   input  wire logic [12:0] tx_bytes_in,
   input  wire logic [5:0]  tx_frames_in,
   output logic             tx_key_out
);
   import mpfc_pkg::*;

   localparam int CNT_W = 24;

   mpfc_byte_if ser_if ();
   mpfc_byte_if des_if ();

   // Configuration and status
   mpfc_flow_t  flow_q, flow_d;
   mpfc_dcd_t   dmode_q, dmode_d;
   logic        key_en_q, key_en_d;
   logic        slip_q, slip_d;
   logic        rej_q, rej_d;
   logic        ovr_q, ovr_d;
   logic        ack_q, ack_d;
   logic [31:0] rdata_q, rdata_d;
   // Pins, handshake and sequencing
   logic [2:0]  rts_s_q, rts_s_d, dtr_s_q, dtr_s_d;
   logic        rts_f_q, rts_f_d, dtr_f_q, dtr_f_d;
   logic        cts_q, cts_d, dcd_q, dcd_d;
   logic        paused_q, paused_d, xoff_sent_q, xoff_sent_d;
   mpfc_state_t st_q, st_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [7:0]  txb_q, txb_d;
   logic        txv_q, txv_d;

   logic        over, flow_ok, ctl_req, have_data, ser_busy, des_ovr, acc;
   logic        wr_ctrl, wr_stat;
   logic [31:0] wd;

   // Buffer pressure drives both CTS and the pause code
   assign over = (tx_bytes_in > 13'(BYTE_LIMIT)) || (tx_frames_in > 6'(FRAME_LIMIT)); // [R7]
   assign ctl_req = (flow_q == MPFC_FLOW_SW) && (over != xoff_sent_q);                // [R22]
   always_comb begin
      unique case (flow_q)
         MPFC_FLOW_HW: flow_ok = dtr_f_q;                  // [R10]
         MPFC_FLOW_SW: flow_ok = ~paused_q;                // [R12] [R21]
         default:      flow_ok = 1'b1;
      endcase
   end
   assign have_data = ctl_req || (rx_valid_in && flow_ok);

   // Control codes jump the queue and ignore the host's pause
   assign ser_if.valid = (st_q == MPFC_S_SEND) && have_data;
   assign ser_if.data  = ctl_req ? (over ? `MPFC_XOFF_CODE : `MPFC_XON_CODE) : rx_byte_in; // [R11]
   assign rx_ready_out = (st_q == MPFC_S_SEND) && !ctl_req && flow_ok && ser_if.ready;
   assign acc          = ser_if.valid && ser_if.ready;
   assign des_if.ready = ~txv_q;

   // Outputs
   assign dsr_out             = 1'b1;  // [R4]
   assign cts_out             = cts_q;
   assign dcd_out             = dcd_q;
   assign tx_byte_out         = txb_q;
   assign tx_valid_out        = txv_q;
   assign tx_key_out          = key_en_q & rts_f_q; // [R8]
   assign avs_readdata_out    = rdata_q;
   assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;

   mpfc_uart_tx #(.CLKS_PER_BIT(CLKS_PER_BIT)) u_ser (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .byte_if    (ser_if.snk),
      .line_out   (rxd_out),
      .busy_out   (ser_busy)
   );

   mpfc_uart_rx #(.CLKS_PER_BIT(CLKS_PER_BIT)) u_des (
      .clk_in      (clk_in),
      .reset_n_in  (reset_n_in),
      .line_in     (txd_in),
      .byte_if     (des_if.src),
      .overrun_out (des_ovr)
   );

   // Register slave: one wait state, writes land on the completing edge
   always_comb begin
      wd       = avs_writedata_in;
      ack_d    = (avs_read_in | avs_write_in) & ~ack_q;
      wr_ctrl  = avs_write_in && ack_q && avs_address_in == `MPFC_OFF_CTRL && avs_byteenable_in[0];
      wr_stat  = avs_write_in && ack_q && avs_address_in == `MPFC_OFF_STATUS && avs_byteenable_in[0];
      flow_d   = flow_q;
      dmode_d  = dmode_q;
      key_en_d = key_en_q;
      slip_d   = slip_q;
      rej_d    = rej_q;
      ovr_d    = ovr_q | des_ovr;
      if (wr_ctrl) begin
         // Illegal mixes leave the old setting in force
         if (mpfc_cfg_legal(wd[`MPFC_CTRL_FLOW_LSB +: 2], wd[`MPFC_CTRL_DCD_LSB +: 2],
                            wd[`MPFC_CTRL_SLIP_BIT])) begin // [R15] [R18] [R19] [R20]
            flow_d   = mpfc_flow_t'(wd[`MPFC_CTRL_FLOW_LSB +: 2]);
            dmode_d  = mpfc_dcd_t'(wd[`MPFC_CTRL_DCD_LSB +: 2]);
            key_en_d = wd[`MPFC_CTRL_KEY_BIT];
            slip_d   = wd[`MPFC_CTRL_SLIP_BIT];
         end else begin
            rej_d = 1'b1;
         end
      end
      // Clear-on-one; a new event in the same cycle wins
      if (wr_stat && wd[`MPFC_ST_REJ_BIT] && !(wr_ctrl && rej_d && !rej_q)) rej_d = 1'b0;
      if (wr_stat && wd[`MPFC_ST_OVR_BIT] && !des_ovr) ovr_d = 1'b0;
      rdata_d = rdata_q;
      if (avs_read_in && !ack_q) begin
         unique case (avs_address_in)
            `MPFC_OFF_CTRL:   rdata_d = {26'h0, slip_q, key_en_q, dmode_q, flow_q};
            `MPFC_OFF_STATUS: rdata_d = {24'h0, ovr_q, tx_key_out, rts_f_q, dtr_f_q, paused_q,
                                         dcd_q, cts_q, rej_q};
            default:          rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // Host pins, CTS and software flow state
   always_comb begin
      rts_s_d     = {rts_s_q[1:0], rts_in};
      dtr_s_d     = {dtr_s_q[1:0], dtr_in};
      rts_f_d     = mpfc_filt(rts_s_q[1], rts_s_q[2], rts_f_q);
      dtr_f_d     = mpfc_filt(dtr_s_q[1], dtr_s_q[2], dtr_f_q);
      cts_d       = rts_f_q & ~over;  // [R5] [R6] [R7]
      paused_d    = paused_q;
      xoff_sent_d = xoff_sent_q;
      txb_d       = txb_q;
      txv_d       = txv_q & ~tx_ready_in;
      if (acc && ctl_req) xoff_sent_d = over;          // [R22]
      if (des_if.valid && des_if.ready) begin
         if (flow_q == MPFC_FLOW_SW && des_if.data == `MPFC_XOFF_CODE) begin
            paused_d = 1'b1;                           // [R21]
         end else if (flow_q == MPFC_FLOW_SW && des_if.data == `MPFC_XON_CODE) begin
            paused_d = 1'b0;                           // [R21]
         end else begin
            txb_d = des_if.data;
            txv_d = 1'b1;
         end
      end
      if (flow_q != MPFC_FLOW_SW) begin
         paused_d    = 1'b0;
         xoff_sent_d = 1'b0;
      end
   end

   // Output sequencing and carrier detect
   always_comb begin
      st_d  = st_q;
      cnt_d = cnt_q;
      unique case (st_q)
         MPFC_S_IDLE: if (have_data) begin
            st_d  = (dmode_q == MPFC_DCD_RXD) ? MPFC_S_LEAD : MPFC_S_SEND;
            cnt_d = '0;
         end
         MPFC_S_LEAD: if (cnt_q == CNT_W'(LEAD_CYCLES - 1)) begin
            st_d = MPFC_S_SEND;                        // [R2]
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
         MPFC_S_SEND: if (!have_data && !ser_busy && !ser_if.valid) begin
            st_d  = (dmode_q == MPFC_DCD_RXD) ? MPFC_S_TAIL : MPFC_S_IDLE;
            cnt_d = '0;
         end
         MPFC_S_TAIL: if (have_data) begin
            st_d = MPFC_S_SEND;
         end else if (cnt_q == CNT_W'(TAIL_CYCLES - 1)) begin
            st_d = MPFC_S_IDLE;                        // [R3]
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
      endcase
      unique case (dmode_q)
         MPFC_DCD_OFF:   dcd_d = 1'b0;                 // [R14]
         MPFC_DCD_RXD:   dcd_d = (st_d != MPFC_S_IDLE); // [R1] [R3]
         MPFC_DCD_RADIO: dcd_d = radio_presence_in;    // [R16]
         MPFC_DCD_PEND:  dcd_d = have_data || (st_d == MPFC_S_SEND) || ser_busy; // [R17]
      endcase
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         flow_q      <= MPFC_FLOW_NONE;
         dmode_q     <= MPFC_DCD_RXD;
         key_en_q    <= 1'b0;
         slip_q      <= 1'b0;
         rej_q       <= 1'b0;
         ovr_q       <= 1'b0;
         ack_q       <= 1'b0;
         rdata_q     <= 32'h0000_0000;
         rts_s_q     <= 3'h0;
         dtr_s_q     <= 3'h0;
         rts_f_q     <= 1'b0;
         dtr_f_q     <= 1'b0;
         cts_q       <= 1'b0;
         dcd_q       <= 1'b0;
         paused_q    <= 1'b0;
         xoff_sent_q <= 1'b0;
         st_q        <= MPFC_S_IDLE;
         cnt_q       <= '0;
         txb_q       <= 8'h00;
         txv_q       <= 1'b0;
      end else begin
         flow_q      <= flow_d;
         dmode_q     <= dmode_d;
         key_en_q    <= key_en_d;
         slip_q      <= slip_d;
         rej_q       <= rej_d;
         ovr_q       <= ovr_d;
         ack_q       <= ack_d;
         rdata_q     <= rdata_d;
         rts_s_q     <= rts_s_d;
         dtr_s_q     <= dtr_s_d;
         rts_f_q     <= rts_f_d;
         dtr_f_q     <= dtr_f_d;
         cts_q       <= cts_d;
         dcd_q       <= dcd_d;
         paused_q    <= paused_d;
         xoff_sent_q <= xoff_sent_d;
         st_q        <= st_d;
         cnt_q       <= cnt_d;
         txb_q       <= txb_d;
         txv_q       <= txv_d;
      end
   end

   property p_dsr;
      @(posedge clk_in) disable iff (!reset_n_in) dsr_out;
   endproperty
   a_dsr: assert property (p_dsr) else $error("dsr not true"); // [R4]

   property p_cts_off;
      @(posedge clk_in) disable iff (!reset_n_in) !rts_f_q |=> !cts_out;
   endproperty
   a_cts_off: assert property (p_cts_off) else $error("cts true without rts"); // [R5]

   property p_cts_on;
      @(posedge clk_in) disable iff (!reset_n_in) $rose(rts_f_q) && !over ##1 !over |-> cts_out;
   endproperty
   a_cts_on: assert property (p_cts_on) else $error("cts late after rts"); // [R6]

   property p_cts_full;
      @(posedge clk_in) disable iff (!reset_n_in)
         (tx_bytes_in > 13'(BYTE_LIMIT) || tx_frames_in > 6'(FRAME_LIMIT)) |=> !cts_out;
   endproperty
   a_cts_full: assert property (p_cts_full) else $error("cts true with full buffer"); // [R7]

   property p_dtr_gate;
      @(posedge clk_in) disable iff (!reset_n_in) (flow_q == MPFC_FLOW_HW) && acc |-> dtr_f_q;
   endproperty
   a_dtr_gate: assert property (p_dtr_gate) else $error("output to host with dtr false"); // [R10]

   property p_pause;
      @(posedge clk_in) disable iff (!reset_n_in) acc && paused_q |-> ctl_req && !rx_ready_out;
   endproperty
   a_pause: assert property (p_pause) else $error("data sent while paused"); // [R21]

   property p_code;
      @(posedge clk_in) disable iff (!reset_n_in)
         acc && ctl_req |-> ser_if.data == (over ? 8'h13 : 8'h11) ##1 xoff_sent_q == $past(over);
   endproperty
   a_code: assert property (p_code) else $error("wrong flow code"); // [R11] [R22]

   property p_dcd_mode;
      @(posedge clk_in) disable iff (!reset_n_in)
         (dmode_q == MPFC_DCD_OFF |=> !dcd_out) and
         (dmode_q == MPFC_DCD_RADIO && $stable(dmode_q) |=> dcd_out == $past(radio_presence_in));
   endproperty
   a_dcd_mode: assert property (p_dcd_mode) else $error("dcd does not follow its mode"); // [R14] [R16]

   property p_dcd_send;
      @(posedge clk_in) disable iff (!reset_n_in) (dmode_q == MPFC_DCD_RXD) && acc |-> dcd_out;
   endproperty
   a_dcd_send: assert property (p_dcd_send) else $error("data without dcd"); // [R1]

   property p_lead;
      @(posedge clk_in) disable iff (!reset_n_in)
         st_q == MPFC_S_LEAD && st_d == MPFC_S_SEND |-> cnt_q == CNT_W'(LEAD_CYCLES - 1) && dcd_out;
   endproperty
   a_lead: assert property (p_lead) else $error("lead time wrong"); // [R2]

   property p_cfg;
      @(posedge clk_in) disable iff (!reset_n_in) mpfc_cfg_legal(flow_q, dmode_q, slip_q);
   endproperty
   a_cfg: assert property (p_cfg) else $error("illegal configuration held"); // [R15] [R18] [R20]

   c_lead: cover property (@(posedge clk_in) disable iff (!reset_n_in) st_q == MPFC_S_LEAD ##1 st_q == MPFC_S_SEND);
   c_xoff: cover property (@(posedge clk_in) disable iff (!reset_n_in) acc && ctl_req && over);
   c_rej:  cover property (@(posedge clk_in) disable iff (!reset_n_in) $rose(rej_q));
   c_tail: cover property (@(posedge clk_in) disable iff (!reset_n_in) st_q == MPFC_S_TAIL ##1 st_q == MPFC_S_IDLE);
endmodule : mpfc_top

// ---- rtl/mpfc_uart_rx.sv ----
// Deserialiser for the transmit-data pin from the host, with a three-stage pin filter.
// Assumes 8N1 framing; a byte with a bad stop bit is dropped.
`include "mpfc_regs.svh"
module mpfc_uart_rx #(
   parameter int unsigned CLKS_PER_BIT = `MPFC_CLK_KHZ * 1000 / `MPFC_BAUD
) (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic reset_n_in,
   // Line
   input  wire logic line_in,
   // Byte stream out
   mpfc_byte_if.src  byte_if,
   output logic      overrun_out
);
   import mpfc_pkg::*;

   logic [2:0]  sync_q, sync_d;
   logic        line_q, line_d;
   logic [7:0]  sh_q, sh_d;
   logic [3:0]  bit_q, bit_d;
   logic [15:0] div_q, div_d;
   logic        vld_q, vld_d;
   logic        ovr_q, ovr_d;

   assign byte_if.data  = sh_q;
   assign byte_if.valid = vld_q;
   assign overrun_out   = ovr_q;

   always_comb begin
      sync_d = {sync_q[1:0], line_in};
      line_d = mpfc_filt(sync_q[1], sync_q[2], line_q);
      sh_d   = sh_q;
      bit_d  = bit_q;
      div_d  = div_q;
      vld_d  = 1'b0;
      ovr_d  = 1'b0;
      if (bit_q == 4'h0) begin
         if (!line_q) begin
            bit_d = 4'(`MPFC_CHAR_BITS);
            div_d = 16'(CLKS_PER_BIT / 2);
         end
      end else if (div_q != 16'h0000) begin
         div_d = div_q - 16'h0001;
      end else begin
         div_d = 16'(CLKS_PER_BIT - 1);
         bit_d = bit_q - 4'h1;
         if (bit_q == 4'(`MPFC_CHAR_BITS) && line_q) begin
            bit_d = 4'h0;
         end else if (bit_q == 4'h1) begin
            vld_d = line_q;
            // No room to hold a byte: the host ignored clear-to-send
            ovr_d = line_q & ~byte_if.ready;
         end else if (bit_q != 4'(`MPFC_CHAR_BITS)) begin
            sh_d = {line_q, sh_q[7:1]};
         end
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sync_q <= 3'h7;
         line_q <= 1'b1;
         sh_q   <= 8'h00;
         bit_q  <= 4'h0;
         div_q  <= 16'h0000;
         vld_q  <= 1'b0;
         ovr_q  <= 1'b0;
      end else begin
         sync_q <= sync_d;
         line_q <= line_d;
         sh_q   <= sh_d;
         bit_q  <= bit_d;
         div_q  <= div_d;
         vld_q  <= vld_d;
         ovr_q  <= ovr_d;
      end
   end
endmodule : mpfc_uart_rx

// ---- rtl/mpfc_uart_tx.sv ----
// Serialiser for the receive-data pin toward the host: 1 start, 8 data, 1 stop.
// Assumes the feeding logic holds data stable while valid is high.
`include "mpfc_regs.svh"
module mpfc_uart_tx #(
   parameter int unsigned CLKS_PER_BIT = `MPFC_CLK_KHZ * 1000 / `MPFC_BAUD
) (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic reset_n_in,
   // Byte stream in
   mpfc_byte_if.snk  byte_if,
   // Line
   output logic      line_out,
   output logic      busy_out
);
   import mpfc_pkg::*;

   logic [9:0]  shift_q, shift_d;
   logic [3:0]  bit_q, bit_d;
   logic [15:0] div_q, div_d;

   assign busy_out      = (bit_q != 4'h0);
   assign byte_if.ready = ~busy_out;
   assign line_out      = shift_q[0];

   always_comb begin
      shift_d = shift_q;
      bit_d   = bit_q;
      div_d   = div_q;
      if (!busy_out) begin
         if (byte_if.valid) begin
            shift_d = {1'b1, byte_if.data, 1'b0};
            bit_d   = 4'(`MPFC_CHAR_BITS);
            div_d   = 16'(CLKS_PER_BIT - 1);
         end
      end else if (div_q == 16'h0000) begin
         shift_d = {1'b1, shift_q[9:1]};
         bit_d   = bit_q - 4'h1;
         div_d   = 16'(CLKS_PER_BIT - 1);
      end else begin
         div_d = div_q - 16'h0001;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         shift_q <= 10'h3ff;
         bit_q   <= 4'h0;
         div_q   <= 16'h0000;
      end else begin
         shift_q <= shift_d;
         bit_q   <= bit_d;
         div_q   <= div_d;
      end
   end
endmodule : mpfc_uart_tx

// ---- verif/mpfc_host_model.sv ----
// Host terminal model: drives RTS, DTR and TXD, decodes 8N1 bytes seen on RXD.
// Assumes CPB clocks per bit on the modem's own clock.
module mpfc_host_model #(
   parameter int unsigned CPB = 4
) (
   // Clock, reset and bench controls
   input  wire logic       clk_in,
   input  wire logic       reset_n_in,
   input  wire logic       accept_in,
   input  wire logic       want_in,
   input  wire logic       send_in,
   input  wire logic [7:0] byte_in,
   // Modem pins
   input  wire logic       rxd_in,
   output logic            dtr_out,
   output logic            rts_out,
   output logic            txd_out,
   // Decoded bytes
   output logic [7:0]      got_out,
   output logic [7:0]      got_cnt_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] ts;
   logic [7:0] sh;
   logic       rbusy;
   int         tc;
   int         t;
   assign dtr_out = accept_in;
   assign rts_out = want_in;
   assign txd_out = (tc > 0) ? ts[0] : 1'b1; // Mark level between frames
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         {rbusy, got_cnt_out, got_out, tc, t} <= '0;
      end else begin
         if (send_in) begin
            ts <= {1'b1, byte_in, 1'b0}; // Frames whatever byte the bench gives: pause, resume or payload alike
            tc <= 10 * CPB;
         end else if (tc > 0) begin
            tc <= tc - 1;
            if (tc % CPB == 1) ts <= {1'b1, ts[9:1]};
         end
         if (!rbusy) begin
            rbusy <= !rxd_in;
            t <= 1;
         end else begin
            t <= t + 1;
            // Mid-bit sampling; the start bit falls out of the shifter
            if (t % CPB == CPB / 2 && t / CPB < 9) sh <= {rxd_in, sh[7:1]};
            if (t == 9 * CPB + CPB / 2) begin
               got_out <= sh;
               got_cnt_out <= got_cnt_out + 8'h01;
               rbusy <= 1'b0;
            end
         end
      end
   end
endmodule : mpfc_host_model

// ---- verif/mpfc_top_tb_top.sv ----
// Self-checking bench for the port flow-control block over its register bus and pins.
// Assumes short LEAD, TAIL and bit times so a run stays well under two thousand cycles.
`include "mpfc_regs.svh"
module mpfc_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_in, reset_n_in, rd, wr, wreq, rts, dtr, txd, rxd, cts, dcd, dsr, key;
   logic        rx_valid, rx_ready, radio, tx_valid, tx_ready, accept, want, hsend;
   logic [3:0]  addr;
   logic [31:0] wdata, rdata, rv;
   logic [7:0]  rx_byte, tx_byte, hbyte, got, got_n, tx_cap, keep;
   logic [12:0] tx_bytes;
   logic [5:0]  tx_frames;
   logic [7:0]  bad [5] = '{8'h03, 8'h01, 8'h0c, 8'h0e, 8'h22};
   int          fail_count = 0, checked = 0, cyc_n = 0, tx_n = 0;

   mpfc_top #(.CLKS_PER_BIT(4), .LEAD_CYCLES(20), .TAIL_CYCLES(40)) i_dut (.clk_in(clk_in),
      .reset_n_in(reset_n_in), .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
      .avs_writedata_in(wdata), .avs_byteenable_in(4'hf), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
      .rts_in(rts), .dtr_in(dtr), .txd_in(txd), .rxd_out(rxd), .cts_out(cts), .dcd_out(dcd), .dsr_out(dsr),
      .rx_byte_in(rx_byte), .rx_valid_in(rx_valid), .rx_ready_out(rx_ready), .radio_presence_in(radio),
      .tx_byte_out(tx_byte), .tx_valid_out(tx_valid), .tx_ready_in(tx_ready), .tx_bytes_in(tx_bytes),
      .tx_frames_in(tx_frames), .tx_key_out(key));
   mpfc_host_model #(.CPB(4)) i_host (.clk_in(clk_in), .reset_n_in(reset_n_in), .accept_in(accept),
      .want_in(want), .send_in(hsend), .byte_in(hbyte), .rxd_in(rxd), .dtr_out(dtr), .rts_out(rts),
      .txd_out(txd), .got_out(got), .got_cnt_out(got_n));

   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cyc_n <= cyc_n + 1;
      if (rx_valid && rx_ready) rx_valid <= 1'b0;
      if (tx_valid && tx_ready) begin
         tx_cap <= tx_byte;
         tx_n <= tx_n + 1;
      end
      if (cyc_n == 20000) begin
         fail_count++;
         wrap_up();
      end
   end

   task automatic wrap_up;
      if (fail_count == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask : cyc
   // One idle edge first, so a release and a new request never share a time step
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_in);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= d;
      do @(posedge clk_in); while (wreq);
      rv = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   task automatic put(input logic [7:0] b);
      rx_byte <= b;
      rx_valid <= 1'b1;
   endtask : put
   task automatic get(input logic [7:0] e);
      logic [7:0] c;
      int         n;
      c = got_n;
      n = 0;
      while (got_n === c && n < 600) begin
         @(posedge clk_in);
         n++;
      end
      chk({got_n, got}, {c + 8'h01, e});
   endtask : get
   task automatic hs(input logic [7:0] b);
      hbyte <= b;
      hsend <= 1'b1;
      @(posedge clk_in);
      hsend <= 1'b0;
      cyc(50);
   endtask : hs
   task automatic cts_at(input logic [12:0] b, input logic [5:0] f, input logic e);
      tx_bytes <= b;
      tx_frames <= f;
      cyc(2);
      chk(cts, e);
   endtask : cts_at

   initial begin
      {rd, wr, rx_valid, radio, want, hsend, reset_n_in} = '0;
      {addr, wdata, rx_byte, hbyte, tx_bytes, tx_frames} = '0;
      {tx_ready, accept} = 2'b11;
      cyc(16);
      reset_n_in <= 1'b1;
      cyc(2);
      chk(dsr, 1);
      chk(cts, 0);
      bus(0, 4'h0, 0);
      chk(rv, 32'h04);
      bus(0, 4'h8, 0);
      chk(rv, 0);
      want <= 1'b1;
      cyc(6);
      chk(cts, 1);
      cts_at(13'd4075, 6'd0, 1);
      cts_at(13'd4076, 6'd0, 0);
      cts_at(13'd0, 6'd30, 0);
      cts_at(13'd0, 6'd29, 1);
      bus(1, 4'h0, 32'h15);
      cyc(1);
      chk(key, 1);
      want <= 1'b0;
      cyc(6);
      chk(cts, 0);
      chk(key, 0);
      put(8'ha5);
      cyc(17);
      chk({dcd, rxd}, 2'b11);
      get(8'ha5);
      cyc(30);
      chk(dcd, 1);
      cyc(20);
      chk(dcd, 0);
      keep = got_n;
      accept <= 1'b0;
      put(8'h3c);
      cyc(150);
      chk(got_n, keep);
      accept <= 1'b1;
      get(8'h3c);
      bus(1, 4'h0, 32'h06);
      accept <= 1'b0;
      put(8'h5a);
      get(8'h5a);
      hs(`MPFC_XOFF_CODE);
      keep = got_n;
      put(8'h66);
      cyc(150);
      chk(got_n, keep);
      hs(`MPFC_XON_CODE);
      get(8'h66);
      hs(8'h42);
      chk({tx_cap, tx_n[7:0]}, 16'h4201);
      cts_at(13'd4076, 6'd0, 0);
      get(`MPFC_XOFF_CODE);
      cts_at(13'd0, 6'd0, 0);
      get(`MPFC_XON_CODE);
      foreach (bad[i]) begin
         bus(1, 4'h4, 32'h01);
         bus(1, 4'h0, {24'h0, bad[i]});
         bus(0, 4'h4, 0);
         chk(rv[0], 1);
         bus(0, 4'h0, 0);
         chk(rv[5:0], 6'h06);
      end
      bus(1, 4'h0, 32'h02);
      put(8'h77);
      get(8'h77);
      chk(dcd, 0);
      bus(1, 4'h0, 32'h0a);
      radio <= 1'b1;
      cyc(3);
      chk(dcd, 1);
      radio <= 1'b0;
      cyc(3);
      chk(dcd, 0);
      bus(1, 4'h0, 32'h0d);
      accept <= 1'b1;
      put(8'h81);
      cyc(6);
      chk(dcd, 1);
      get(8'h81);
      wrap_up();
   end
endmodule : mpfc_top_tb_top
